// File: tag_file_apdu_interpreter.sv
// Command interpreter for select, binary read/update and password verify
`timescale 1ns/100ps
module tag_file_apdu_interpreter (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic SESSION_START,
    input wire logic [7:0] CMD_DATA,
    input wire logic CMD_VALID,
    input wire logic CMD_LAST,
    output logic CMD_READY,
    output logic [7:0] RSP_DATA,
    output logic RSP_VALID,
    output logic RSP_LAST,
    input wire logic RSP_READY,
    input wire logic [7:0] READ_ACCESS,
    input wire logic [7:0] WRITE_ACCESS,
    input wire logic [127:0] READ_PWD,
    input wire logic [127:0] WRITE_PWD,
    input wire logic MEM_FAULT
);
    import tag_apdu_pkg::*;

    function automatic logic [15:0] file_len(input file_e f);
        file_len = (f == F_SYS) ? SYS_LEN : ((f == F_DATA) ? DATA_LEN : 16'h0000);
    endfunction : file_len

    function automatic logic [MEM_AW-1:0] file_base(input file_e f);
        file_base = (f == F_SYS) ? SYS_BASE : DATA_BASE;
    endfunction : file_base

    function automatic logic fits(input logic [15:0] off, input logic [7:0] n,
                                  input logic [15:0] len);
        fits = ({1'b0, off} + {9'h000, n}) <= {1'b0, len};
    endfunction : fits

    function automatic logic rd_allowed(input file_e f, input logic [7:0] acc,
                                        input logic grant);
        rd_allowed = (f == F_SYS) || ((f == F_DATA) && ((acc == ACC_FREE) || grant));
    endfunction : rd_allowed

    function automatic logic wr_allowed(input file_e f, input logic [7:0] acc,
                                        input logic grant);
        wr_allowed = (f == F_DATA) && ((acc == ACC_FREE) || grant);
    endfunction : wr_allowed

    state_e state_reg, state_next;
    file_e cur_file_reg, cur_file_next;
    logic [8:0] cnt_reg, cnt_next;
    logic [7:0] cla_reg, cla_next, ins_reg, ins_next;
    logic [7:0] p1_reg, p1_next, p2_reg, p2_next, p3_reg, p3_next;
    logic [15:0] fid_reg, fid_next, sw_reg, sw_next;
    logic pwd_bad_reg, pwd_bad_next, fault_reg, fault_next;
    logic upd_ok_reg, upd_ok_next;
    logic rd_grant_reg, rd_grant_next, wr_grant_reg, wr_grant_next;
    logic [1:0] retry_reg, retry_next;
    logic [MEM_AW-1:0] rd_ptr_reg, rd_ptr_next;
    logic [7:0] rd_left_reg, rd_left_next;
    logic cmd_ready_reg, cmd_ready_next;
    logic [7:0] e0_reg, e0_next, e1_reg, e1_next;
    logic l0_reg, l0_next, l1_reg, l1_next, v0_reg, v0_next, v1_reg, v1_next;
    logic push, push_last, pop, room;
    logic [7:0] push_data, idx, ref_byte;
    logic [15:0] off, flen;
    logic mem_we;
    logic [MEM_AW-1:0] mem_waddr;
    logic [7:0] mem_rdata;

    file_mem u_mem (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(CMD_DATA),
        .raddr(rd_ptr_reg),
        .rdata(mem_rdata)
    );

    assign off = {p1_reg, p2_reg};
    assign flen = file_len(cur_file_reg);
    assign idx = cnt_reg[7:0] - HDR_LEN[7:0];
    assign room = !v1_reg;
    assign pop = v0_reg && RSP_READY;

    always_comb begin
        state_next = state_reg;
        cur_file_next = cur_file_reg;
        cnt_next = cnt_reg;
        cla_next = cla_reg;
        ins_next = ins_reg;
        p1_next = p1_reg;
        p2_next = p2_reg;
        p3_next = p3_reg;
        fid_next = fid_reg;
        sw_next = sw_reg;
        pwd_bad_next = pwd_bad_reg;
        fault_next = fault_reg;
        upd_ok_next = upd_ok_reg;
        rd_grant_next = rd_grant_reg;
        wr_grant_next = wr_grant_reg;
        retry_next = retry_reg;
        rd_ptr_next = rd_ptr_reg;
        rd_left_next = rd_left_reg;
        mem_we = 1'b0;
        mem_waddr = file_base(cur_file_reg) + off[MEM_AW-1:0] + {1'b0, idx};
        push = 1'b0;
        push_data = 8'h00;
        push_last = 1'b0;
        ref_byte = (off == PWD_WRITE) ? WRITE_PWD[8*(15-idx[3:0]) +: 8]
                                      : READ_PWD[8*(15-idx[3:0]) +: 8];
        case (state_reg)
            ST_COLLECT: begin
                if (CMD_VALID) begin
                    if (cnt_reg != CNT_MAX) begin
                        cnt_next = cnt_reg + 9'h001;
                    end
                    if (cnt_reg == 9'h000) begin
                        cla_next = CMD_DATA;
                    end else if (cnt_reg == 9'h001) begin
                        ins_next = CMD_DATA;
                    end else if (cnt_reg == 9'h002) begin
                        p1_next = CMD_DATA;
                    end else if (cnt_reg == 9'h003) begin
                        p2_next = CMD_DATA;
                    end else if (cnt_reg == 9'h004) begin
                        p3_next = CMD_DATA;
                        // Writes are armed only for an update whose header passes the class, length, range and access checks
                        upd_ok_next = (cla_reg == CLA_STD) && (ins_reg == INS_UPDATE)
                            && (CMD_DATA >= LEN_MIN) && (CMD_DATA <= LC_UPD_MAX)
                            && fits(off, CMD_DATA, flen)
                            && wr_allowed(cur_file_reg, WRITE_ACCESS, wr_grant_reg);
                    end else begin
                        fid_next = {fid_reg[7:0], CMD_DATA};
                        if ((cnt_reg < PWD_APDU_LEN) && (CMD_DATA != ref_byte)) begin
                            pwd_bad_next = 1'b1;
                        end
                        if (upd_ok_reg && (idx < p3_reg) && (cnt_reg[8] == 1'b0)) begin
                            mem_we = 1'b1;
                            fault_next = fault_reg | MEM_FAULT;
                        end
                    end
                    if (CMD_LAST) begin
                        state_next = ST_EVAL;
                    end
                end
            end
            ST_EVAL: begin
                state_next = ST_SW1;
                sw_next = SW_OK;
                if (cla_reg != CLA_STD) begin
                    sw_next = SW_CLA;
                end else if (ins_reg == INS_SELECT) begin
                    if ((p1_reg != P1_SEL) || (p2_reg != P2_SEL)) begin
                        sw_next = SW_P1P2;
                    end else if ((p3_reg != LC_SEL) || (cnt_reg != SEL_APDU_LEN)) begin
                        sw_next = SW_LEN;
                    end else if (fid_reg == FID_SYS) begin
                        cur_file_next = F_SYS;
                    end else if (fid_reg == FID_DATA) begin
                        cur_file_next = F_DATA;
                    end else begin
                        sw_next = SW_NOT_FOUND;
                        cur_file_next = F_NONE;
                    end
                end else if (ins_reg == INS_READ) begin
                    if (cur_file_reg == F_NONE) begin
                        sw_next = SW_NOT_FOUND;
                    end else if ((cnt_reg != HDR_LEN) || (p3_reg < LEN_MIN)
                                 || !fits(off, p3_reg, flen)) begin
                        sw_next = SW_LEN;
                    end else if (!rd_allowed(cur_file_reg, READ_ACCESS, rd_grant_reg)) begin
                        sw_next = SW_SEC;
                    end else begin
                        rd_ptr_next = file_base(cur_file_reg) + off[MEM_AW-1:0];
                        rd_left_next = p3_reg;
                        state_next = ST_RD_ADDR;
                    end
                end else if (ins_reg == INS_UPDATE) begin
                    if (cur_file_reg == F_NONE) begin
                        sw_next = SW_NOT_FOUND;
                    end else if ((p3_reg < LEN_MIN) || (p3_reg > LC_UPD_MAX)
                                 || (cnt_reg != HDR_LEN + {1'b0, p3_reg})
                                 || !fits(off, p3_reg, flen)) begin
                        sw_next = SW_LEN;
                    end else if (!wr_allowed(cur_file_reg, WRITE_ACCESS, wr_grant_reg)) begin
                        sw_next = SW_SEC;
                    end else if (fault_reg) begin
                        sw_next = SW_UPD_FAIL;
                    end
                end else if (ins_reg == INS_VERIFY) begin
                    if ((off != PWD_READ) && (off != PWD_WRITE)) begin
                        sw_next = SW_P1P2;
                    end else if ((cur_file_reg == F_NONE) || (WRITE_ACCESS == ACC_LOCK_W)
                                 || (READ_ACCESS == ACC_LOCK_R)) begin
                        sw_next = SW_REF;
                    end else if (cur_file_reg != F_DATA) begin
                        sw_next = SW_STRUCT;
                    end else if (p3_reg == LC_PWD_NONE) begin
                        if (cnt_reg != HDR_LEN) begin
                            sw_next = SW_PARAM;
                        end else if ((off == PWD_READ) ? !rd_allowed(F_DATA, READ_ACCESS,
                                     rd_grant_reg) : !wr_allowed(F_DATA, WRITE_ACCESS,
                                     wr_grant_reg)) begin
                            sw_next = SW_PWD_REQ;
                        end
                    end else if ((p3_reg != LC_PWD) || (cnt_reg != PWD_APDU_LEN)) begin
                        sw_next = SW_PARAM;
                    end else if (retry_reg == 2'h0) begin
                        sw_next = SW_PWD_BAD;
                    end else if (pwd_bad_reg) begin
                        retry_next = retry_reg - 2'h1;
                        sw_next = SW_PWD_BAD | {14'h0000, retry_reg - 2'h1};
                    end else if (off == PWD_READ) begin
                        rd_grant_next = 1'b1;
                    end else begin
                        wr_grant_next = 1'b1;
                    end
                end else begin
                    sw_next = SW_INS;
                end
            end
            ST_RD_ADDR: begin
                state_next = ST_RD_PUSH;
            end
            ST_RD_PUSH: begin
                if (room) begin
                    push = 1'b1;
                    push_data = mem_rdata;
                    rd_ptr_next = rd_ptr_reg + 9'h001;
                    rd_left_next = rd_left_reg - 8'h01;
                    state_next = (rd_left_reg == 8'h01) ? ST_SW1 : ST_RD_ADDR;
                end
            end
            ST_SW1: begin
                if (room) begin
                    push = 1'b1;
                    push_data = sw_reg[15:8];
                    state_next = ST_SW2;
                end
            end
            ST_SW2: begin
                if (room) begin
                    push = 1'b1;
                    push_data = sw_reg[7:0];
                    push_last = 1'b1;
                    state_next = ST_COLLECT;
                    cnt_next = 9'h000;
                    pwd_bad_next = 1'b0;
                    fault_next = 1'b0;
                    upd_ok_next = 1'b0;
                    fid_next = 16'h0000;
                end
            end
            default: begin
                state_next = ST_COLLECT;
            end
        endcase
        if (SESSION_START) begin
            cur_file_next = F_NONE;
            rd_grant_next = 1'b0;
            wr_grant_next = 1'b0;
            retry_next = RETRY_MAX;
        end
        cmd_ready_next = (state_next == ST_COLLECT);
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= ST_COLLECT;
            cur_file_reg <= F_NONE;
            cnt_reg <= 9'h000;
            cla_reg <= 8'h00;
            ins_reg <= 8'h00;
            p1_reg <= 8'h00;
            p2_reg <= 8'h00;
            p3_reg <= 8'h00;
            fid_reg <= 16'h0000;
            sw_reg <= 16'h0000;
            pwd_bad_reg <= 1'b0;
            fault_reg <= 1'b0;
            upd_ok_reg <= 1'b0;
            rd_grant_reg <= 1'b0;
            wr_grant_reg <= 1'b0;
            retry_reg <= RETRY_MAX;
            rd_ptr_reg <= 9'h000;
            rd_left_reg <= 8'h00;
            cmd_ready_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cur_file_reg <= cur_file_next;
            cnt_reg <= cnt_next;
            cla_reg <= cla_next;
            ins_reg <= ins_next;
            p1_reg <= p1_next;
            p2_reg <= p2_next;
            p3_reg <= p3_next;
            fid_reg <= fid_next;
            sw_reg <= sw_next;
            pwd_bad_reg <= pwd_bad_next;
            fault_reg <= fault_next;
            upd_ok_reg <= upd_ok_next;
            rd_grant_reg <= rd_grant_next;
            wr_grant_reg <= wr_grant_next;
            retry_reg <= retry_next;
            rd_ptr_reg <= rd_ptr_next;
            rd_left_reg <= rd_left_next;
            cmd_ready_reg <= cmd_ready_next;
        end
    end

    // Two-entry response buffer, head entry drives the ports
    always_comb begin
        e0_next = e0_reg;
        l0_next = l0_reg;
        v0_next = v0_reg;
        e1_next = e1_reg;
        l1_next = l1_reg;
        v1_next = v1_reg;
        if (pop) begin
            e0_next = e1_reg;
            l0_next = l1_reg;
            v0_next = v1_reg;
            v1_next = 1'b0;
        end
        if (push) begin
            if (v0_next) begin
                e1_next = push_data;
                l1_next = push_last;
                v1_next = 1'b1;
            end else begin
                e0_next = push_data;
                l0_next = push_last;
                v0_next = 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            e0_reg <= 8'h00;
            l0_reg <= 1'b0;
            v0_reg <= 1'b0;
            e1_reg <= 8'h00;
            l1_reg <= 1'b0;
            v1_reg <= 1'b0;
        end else begin
            e0_reg <= e0_next;
            l0_reg <= l0_next;
            v0_reg <= v0_next;
            e1_reg <= e1_next;
            l1_reg <= l1_next;
            v1_reg <= v1_next;
        end
    end

    assign CMD_READY = cmd_ready_reg;
    assign RSP_DATA = e0_reg;
    assign RSP_VALID = v0_reg;
    assign RSP_LAST = l0_reg;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    logic eval_ok;
    assign eval_ok = (state_reg == ST_EVAL) && (cla_reg == CLA_STD) && !SESSION_START;

    a_sel_success: assert property ((eval_ok && ins_reg == INS_SELECT && fid_reg == FID_SYS
        && sw_next == SW_OK) |=> (cur_file_reg == F_SYS) && (sw_reg == SW_OK))
        else $error("system select did not take effect");
    a_sel_missing: assert property ((eval_ok && ins_reg == INS_SELECT && sw_next == SW_NOT_FOUND)
        |=> (state_reg == ST_SW1) && (cur_file_reg == F_NONE))
        else $error("missing file select returned data or kept file");
    a_read_range: assert property ((state_reg == ST_EVAL && state_next == ST_RD_ADDR)
        |-> fits(off, p3_reg, flen) && (p3_reg >= LEN_MIN))
        else $error("read started outside the file");
    a_read_status: assert property ((state_reg == ST_RD_PUSH && room && rd_left_reg == 8'h01)
        |=> (state_reg == ST_SW1) && (sw_reg == SW_OK))
        else $error("read did not end with success status");
    a_update_guard: assert property (mem_we |-> upd_ok_reg && (ins_reg == INS_UPDATE))
        else $error("write without a valid update");
    a_unknown_ins: assert property ((eval_ok && ins_reg != INS_SELECT && ins_reg != INS_READ
        && ins_reg != INS_UPDATE && ins_reg != INS_VERIFY) |=> sw_reg == SW_INS)
        else $error("unknown instruction not refused");
    a_verify_ref: assert property ((eval_ok && ins_reg == INS_VERIFY && cur_file_reg == F_NONE
        && (off == PWD_READ || off == PWD_WRITE)) |=> sw_reg == SW_REF)
        else $error("verify without data file not refused");
    a_retry_step: assert property ((retry_reg != $past(retry_reg) && !$past(SESSION_START))
        |-> (retry_reg == $past(retry_reg) - 2'h1) && (sw_reg[7:4] == 4'hc))
        else $error("retry counter moved wrongly");
    a_no_retry: assert property ((eval_ok && ins_reg == INS_VERIFY && retry_reg == 2'h0)
        |=> $stable(rd_grant_reg) && $stable(wr_grant_reg) && (retry_reg == 2'h0))
        else $error("access changed with no retries left");
    a_session_clear: assert property (SESSION_START |=> (cur_file_reg == F_NONE)
        && !rd_grant_reg && !wr_grant_reg && (retry_reg == RETRY_MAX))
        else $error("session state carried over");
    a_rsp_hold: assert property ((RSP_VALID && !RSP_READY) |=> RSP_VALID && $stable(RSP_DATA))
        else $error("response byte lost under stall");

    c_read_done: cover property (state_reg == ST_RD_PUSH ##1 state_reg == ST_SW1);
    c_pwd_grant: cover property ($rose(rd_grant_reg) || $rose(wr_grant_reg));
    c_update_ok: cover property (mem_we ##[1:300] (state_reg == ST_SW2 && sw_reg == SW_OK));
    c_stall_full: cover property (v1_reg && !RSP_READY);
endmodule : tag_file_apdu_interpreter

// File: tag_apdu_pkg.sv
// Constants, status words and state types of the tag command interpreter
package tag_apdu_pkg;
    localparam logic [7:0] CLA_STD = 8'h00;
    localparam logic [7:0] INS_SELECT = 8'ha4;
    localparam logic [7:0] INS_READ = 8'hb0;
    localparam logic [7:0] INS_UPDATE = 8'hd6;
    localparam logic [7:0] INS_VERIFY = 8'h20;
    localparam logic [7:0] P1_SEL = 8'h00;
    localparam logic [7:0] P2_SEL = 8'h0c;
    localparam logic [7:0] LC_SEL = 8'h02;
    localparam logic [15:0] FID_SYS = 16'he101;
    localparam logic [15:0] FID_DATA = 16'h0001;
    localparam logic [7:0] LEN_MIN = 8'h01;
    localparam logic [7:0] LC_UPD_MAX = 8'hf6;
    localparam logic [7:0] LC_PWD_NONE = 8'h00;
    localparam logic [7:0] LC_PWD = 8'h10;
    localparam logic [15:0] PWD_READ = 16'h0001;
    localparam logic [15:0] PWD_WRITE = 16'h0002;
    localparam logic [7:0] ACC_FREE = 8'h00;
    localparam logic [7:0] ACC_LOCK_W = 8'hff;
    localparam logic [7:0] ACC_LOCK_R = 8'hfe;
    localparam logic [1:0] RETRY_MAX = 2'h3;
    localparam logic [8:0] HDR_LEN = 9'h005;
    localparam logic [8:0] SEL_APDU_LEN = 9'h007;
    localparam logic [8:0] PWD_APDU_LEN = 9'h015;
    localparam logic [8:0] CNT_MAX = 9'h1ff;
    localparam int MEM_AW = 9;
    localparam logic [MEM_AW-1:0] SYS_BASE = 9'h000;
    localparam logic [MEM_AW-1:0] DATA_BASE = 9'h100;
    localparam logic [15:0] SYS_LEN = 16'h0012;
    localparam logic [15:0] DATA_LEN = 16'h0100;
    localparam logic [15:0] SW_OK = 16'h9000;
    localparam logic [15:0] SW_PWD_REQ = 16'h6300;
    localparam logic [15:0] SW_PWD_BAD = 16'h63c0;
    localparam logic [15:0] SW_UPD_FAIL = 16'h6581;
    localparam logic [15:0] SW_LEN = 16'h6700;
    localparam logic [15:0] SW_STRUCT = 16'h6981;
    localparam logic [15:0] SW_SEC = 16'h6982;
    localparam logic [15:0] SW_REF = 16'h6984;
    localparam logic [15:0] SW_PARAM = 16'h6a80;
    localparam logic [15:0] SW_NOT_FOUND = 16'h6a82;
    localparam logic [15:0] SW_P1P2 = 16'h6a86;
    localparam logic [15:0] SW_INS = 16'h6d00;
    localparam logic [15:0] SW_CLA = 16'h6e00;

    typedef enum logic [1:0] {
        F_NONE = 2'b00,
        F_SYS = 2'b01,
        F_DATA = 2'b10
    } file_e;

    typedef enum logic [2:0] {
        ST_COLLECT = 3'b000,
        ST_EVAL = 3'b001,
        ST_RD_ADDR = 3'b010,
        ST_RD_PUSH = 3'b011,
        ST_SW1 = 3'b100,
        ST_SW2 = 3'b101
    } state_e;
endpackage : tag_apdu_pkg

// File: file_mem.sv
// Byte memory holding the system file and the data file
`timescale 1ns/100ps
module file_mem (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [tag_apdu_pkg::MEM_AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [tag_apdu_pkg::MEM_AW-1:0] raddr,
    output logic [7:0] rdata
);
    import tag_apdu_pkg::*;

    logic [7:0] mem [0:(1<<MEM_AW)-1];
    logic [7:0] rdata_reg;

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= mem[raddr];
        end
    end

    assign rdata = rdata_reg;
endmodule : file_mem

// File: rf_host_sink.sv
// Response sink of the reader host, prompt or stalling every other cycle
`timescale 1ns/100ps
module rf_host_sink (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    output logic ready
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready <= 1'b0;
        end else begin
            ready <= slow ? ~ready : 1'b1;
        end
    end
endmodule : rf_host_sink

// File: tb_top.sv
// Testbench of the tag command interpreter with queued response checks
`timescale 1ns/100ps
module tb_top;
    import tag_apdu_pkg::*;
    logic clk = 0, rst_n = 0, ses = 0, cv = 0, cl = 0, mf = 0, slow = 0;
    logic [7:0] cd = 0, ra = 0, wa = 0, d0, d1;
    logic [127:0] rp = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
    logic [127:0] wp = 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
    wire cr, rv, rl, rr;
    wire [7:0] rd;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'h2115;
    int n_errors = 0, compares = 0;
    tag_file_apdu_interpreter tag_file_apdu_interpreter_i (.REF_CLK(clk), .RST_N(rst_n),
        .SESSION_START(ses), .CMD_DATA(cd), .CMD_VALID(cv), .CMD_LAST(cl), .CMD_READY(cr),
        .RSP_DATA(rd), .RSP_VALID(rv), .RSP_LAST(rl), .RSP_READY(rr), .READ_ACCESS(ra),
        .WRITE_ACCESS(wa), .READ_PWD(rp), .WRITE_PWD(wp), .MEM_FAULT(mf));
    rf_host_sink rf_host_sink_i (.clk(clk), .rst_n(rst_n), .slow(slow), .ready(rr));
    initial forever #5 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task chk(input logic [7:0] got, input logic [7:0] want);
        compares++;
        if (got !== want) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h want=%h", $time, got, want);
        end
    endtask : chk
    // Oldest note against each consumed byte; last flag only on final byte
    always @(negedge clk) begin
        if (rv && rr) begin
            chk(rd, exp_q.size() ? exp_q.pop_front() : 8'hxx);
            chk({7'h0, rl}, {7'h0, exp_q.size() == 0});
        end
    end
    task automatic apdu(input logic [7:0] c[$], input logic [7:0] r[$]);
        int k;
        exp_q = r;
        foreach (c[i]) begin
            k = 0;
            while (!cr && k < 3000) begin
                @(negedge clk);
                k++;
            end
            if (k >= 3000) n_errors++;
            cd = c[i];
            cv = 1;
            cl = (i == c.size() - 1);
            @(negedge clk);
        end
        cv = 0;
        cl = 0;
        // Command side must close once the last byte is taken
        chk({7'h0, cr}, 8'h00);
        while (exp_q.size()) @(negedge clk);
    endtask : apdu
    task automatic sel(input logic [15:0] id, input logic [15:0] sw);
        apdu('{8'h00, INS_SELECT, P1_SEL, P2_SEL, LC_SEL, id[15:8], id[7:0]}, '{sw[15:8], sw[7:0]});
    endtask : sel
    task automatic vfy(input logic [7:0] p2, input logic [127:0] pw, input logic [15:0] sw);
        logic [7:0] c[$];
        c = '{8'h00, INS_VERIFY, 8'h00, p2, LC_PWD};
        for (int i = 15; i >= 0; i--) c.push_back(pw[i*8 +: 8]);
        apdu(c, '{sw[15:8], sw[7:0]});
    endtask : vfy
    task test_done;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    initial begin
        #500000;
        n_errors++;
        test_done;
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1;
        @(negedge clk);
        sel(FID_SYS, SW_OK);
        apdu('{8'h00, INS_VERIFY, 8'h00, 8'h01, 8'h00}, '{8'h69, 8'h81});
        sel(16'he102, SW_NOT_FOUND);
        apdu('{8'h00, INS_READ, 8'h00, 8'h00, 8'h02}, '{8'h6a, 8'h82});
        apdu('{8'h00, 8'h24, 8'h00, 8'h01, 8'h00}, '{8'h6d, 8'h00});
        apdu('{8'h80, INS_READ, 8'h00, 8'h00, 8'h01}, '{8'h6e, 8'h00});
        $display("test select and errors done");
        seed = lfsr(seed);
        d0 = seed[7:0];
        seed = lfsr(seed);
        d1 = seed[7:0];
        slow = seed[8];
        sel(FID_DATA, SW_OK);
        apdu('{8'h00, INS_UPDATE, 8'h00, 8'hf0, 8'h02, d0, d1}, '{8'h90, 8'h00});
        slow = 1;
        apdu('{8'h00, INS_READ, 8'h00, 8'hf0, 8'h02}, '{d0, d1, 8'h90, 8'h00});
        apdu('{8'h00, INS_READ, 8'h00, 8'hff, 8'h02}, '{8'h67, 8'h00});
        mf = 1;
        apdu('{8'h00, INS_UPDATE, 8'h00, 8'hf2, 8'h01, d0}, '{8'h65, 8'h81});
        mf = 0;
        $display("test data path done");
        apdu('{8'h00, INS_VERIFY, 8'h00, 8'h03, 8'h00}, '{8'h6a, 8'h86});
        apdu('{8'h00, INS_VERIFY, 8'h00, 8'h01, 8'h00}, '{8'h90, 8'h00});
        apdu('{8'h00, INS_VERIFY, 8'h00, 8'h01, 8'h05}, '{8'h6a, 8'h80});
        ra = 8'h80;
        apdu('{8'h00, INS_READ, 8'h00, 8'hf0, 8'h02}, '{8'h69, 8'h82});
        apdu('{8'h00, INS_VERIFY, 8'h00, 8'h01, 8'h00}, '{8'h63, 8'h00});
        for (int i = 2; i >= 0; i--) vfy(8'h01, wp, {8'h63, 4'hc, i[3:0]});
        vfy(8'h01, rp, SW_PWD_BAD);
        apdu('{8'h00, INS_READ, 8'h00, 8'hf0, 8'h02}, '{8'h69, 8'h82});
        ses = 1;
        @(negedge clk);
        ses = 0;
        apdu('{8'h00, INS_READ, 8'h00, 8'hf0, 8'h02}, '{8'h6a, 8'h82});
        sel(FID_DATA, SW_OK);
        vfy(8'h01, rp, SW_OK);
        apdu('{8'h00, INS_READ, 8'h00, 8'hf0, 8'h02}, '{d0, d1, 8'h90, 8'h00});
        wa = 8'hff;
        vfy(8'h02, wp, SW_REF);
        wa = 8'h00;
        ra = 8'hfe;
        vfy(8'h01, rp, SW_REF);
        $display("test passwords done");
        test_done;
    end
endmodule : tb_top
